// [core/epc_pulse_gen.sv]
// energy accumulator with threshold pulse counter and width timer
// assumes: tick_i is a one-cycle strobe on clk_i
`timescale 1ns/100ps
`include "epc_defs.svh"
module epc_pulse_gen #(
  parameter int ACC_W = 32,
  parameter int WID_W = 24
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic ce_i, // clock enable
  input wire logic en_i, // accumulator and counter enable
  input wire logic tick_i, // accumulation strobe
  input wire logic [ACC_W-1:0] power_i, // power sample
  input wire logic [ACC_W-1:0] thresh_i, // energy per pulse
  input wire logic [1:0] speed_i, // speed-up field
  input wire logic [WID_W-1:0] width_i, // pulse width, cycles
  output logic [ACC_W-1:0] acc_o, // accumulated energy
  output logic pulse_o, // pulse, active high
  output logic fire_o // one-cycle threshold crossing
);
  import epc_pkg::*;
  // refuse sizes the counters cannot serve
  if (ACC_W < 1 || WID_W < 2) begin : g_chk
    $error("epc_pulse_gen needs ACC_W >= 1 and WID_W >= 2");
  end
  epc_pg_state_t st_r, st_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt, thr_eff;
  logic [ACC_W:0] sum;
  logic [WID_W-1:0] cnt_r, cnt_nxt;
  logic fire_r, fire_nxt;
  logic [2:0] sh;
  //////////////////////////////////////////////////////////////////
  // speed-up divides the energy step, so pulses come faster
  always_comb begin
    case (speed_i)
      2'h1: sh = `EPC_SH_X4;
      2'h2: sh = `EPC_SH_X8;
      2'h3: sh = `EPC_SH_X16;
      default: sh = 3'h0;
    endcase
    thr_eff = thresh_i >> sh;
  end
  // accumulate, pulse on crossing, keep remainder; zero step stalls
  always_comb begin
    sum = {1'b0, acc_r} + {1'b0, power_i};
    acc_nxt = acc_r;
    fire_nxt = 1'b0;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (!en_i) begin
      acc_nxt = '0;
    end else if (tick_i && thr_eff != '0) begin
      if (sum >= {1'b0, thr_eff}) begin
        acc_nxt = ACC_W'(sum - {1'b0, thr_eff});
        fire_nxt = 1'b1;
      end else begin
        acc_nxt = ACC_W'(sum);
      end
    end
    // crossings during a running pulse still count but do not stretch it
    case (st_r)
      EPC_PG_IDLE: if (fire_r) begin
        st_nxt = EPC_PG_HIGH;
        cnt_nxt = WID_W'(width_i - 1'b1);
      end
      EPC_PG_HIGH: if (cnt_r == '0) begin
        st_nxt = EPC_PG_IDLE;
      end else begin
        cnt_nxt = WID_W'(cnt_r - 1'b1);
      end
      default: st_nxt = EPC_PG_IDLE;
    endcase
  end
  // state registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= '0;
      fire_r <= 1'b0;
      st_r <= EPC_PG_IDLE;
      cnt_r <= '0;
    end else if (ce_i) begin
      acc_r <= acc_nxt;
      fire_r <= fire_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign acc_o = acc_r;
  assign fire_o = fire_r;
  assign pulse_o = (st_r == EPC_PG_HIGH);
  //////////////////////////////////////////////////////////////////
  property p_pulse_start;  // crossing starts a pulse
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && fire_r && !pulse_o) |=> (pulse_o && cnt_r == WID_W'($past(width_i) - 1'b1));
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");
  property p_pulse_end;  // pulse ends after width
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && pulse_o && cnt_r == '0) |=> !pulse_o;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse overran width");
endmodule // epc_pulse_gen

// [core/epc_top.sv]
// energy pulse output control: control registers, accumulators,
// pulse output, creep detection and interrupt, on an APB slave
// assumes: metering inputs are on clk_i; APB master on clk_i
`timescale 1ns/100ps
`include "epc_defs.svh"
module epc_top #(
  parameter int ACC_W = 32,
  parameter int PULSE_CYC = `EPC_PULSE_CYC_BASE,
  parameter logic [ACC_W-1:0] CONST_VAL = 1
) (
  input wire logic clk_i, // core clock, 100 MHz
  input wire logic rst_i, // async reset, high
  input wire logic ce_i, // clock enable, freezes all
  input epc_pkg::epc_apb_req_t apb_i, // apb request
  output epc_pkg::epc_apb_rsp_t apb_o, // apb answer
  input wire logic [ACC_W-1:0] power1_i, // power, channel one
  input wire logic [ACC_W-1:0] power2_i, // power, channel two
  input wire logic [ACC_W-1:0] irms_i, // current rms
  input wire logic [ACC_W-1:0] fund_i, // fundamental channel
  input wire logic [ACC_W-1:0] avg_power_i, // averaged power
  input wire logic avg_valid_i, // averaged power strobe
  output logic energy_pulse_out_one_o, // pulse output one
  output logic [ACC_W-1:0] acc4_in_o, // accumulator four input
  output logic creep_o, // creep status
  output logic irq_o // interrupt, level high
);
  import epc_pkg::*;
  localparam int WID_W = $clog2(PULSE_CYC + 1);
  localparam int TICK_W = $clog2(`EPC_TICK_DIV + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`EPC_TICK_DIV - 1);
  // refuse widths that the logic cannot serve
  if (ACC_W < 11 || ACC_W > 32) begin : g_chk_w
    $error("ACC_W must lie in 11..32");
  end
  if (PULSE_CYC < 8) begin : g_chk_p
    $error("PULSE_CYC must be at least 8");
  end
  //////////////////////////////////////////////////////////////////
  // register state
  epc_ctrl1_t ctrl1_r, ctrl1_nxt;
  epc_in_mode_t mode4_r, mode4_nxt;
  logic [ACC_W-1:0] pthr_r, pthr_nxt, cthr_r, cthr_nxt;
  logic [`EPC_EV_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt, rd_val;
  logic err_r, err_nxt, hit;
  logic setup, wr_acc;
  logic [5:0] idx;
  // processing state
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [ACC_W-1:0] fast_r, fast_nxt, acc4_r, acc4_nxt;
  logic [1:0] crun_r, crun_nxt;
  logic creep_r, creep_nxt, out_r, out_nxt;
  logic en1, en2, p1, p2, f1, f2, src_pulse;
  logic [ACC_W-1:0] acc1, acc2;
  logic [WID_W-1:0] width;
  //////////////////////////////////////////////////////////////////
  // apb decode; ce low stalls the bus via pready
  assign setup = apb_i.psel && !apb_i.penable && ce_i;
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite && ce_i && !err_r;
  assign idx = apb_i.paddr[7:2];
  // read mux, unimplemented bits read zero
  always_comb begin
    hit = 1'b1;
    rd_val = `EPC_ZERO32;
    case (idx)
      `EPC_IDX_CTRL1: rd_val = 32'(ctrl1_r);
      `EPC_IDX_CTRL2: rd_val[`EPC_MODE4_LSB +: `EPC_MODE4_W] = mode4_r;
      `EPC_IDX_PTHR: rd_val = 32'(pthr_r);
      `EPC_IDX_CTHR: rd_val = 32'(cthr_r);
      `EPC_IDX_ISTAT: begin
        rd_val[`EPC_EV_W-1:0] = ist_r;
        rd_val[`EPC_ST_LIVE] = creep_r;
      end
      `EPC_IDX_IMASK: rd_val[`EPC_EV_W-1:0] = imask_r;
      `EPC_IDX_FAST: rd_val = 32'(fast_r);
      `EPC_IDX_ACC1: rd_val = 32'(acc1);
      `EPC_IDX_ACC2: rd_val = 32'(acc2);
      default: hit = 1'b0;
    endcase
    if (apb_i.paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end
  end
  // read data and error are caught at setup, so they come from flops
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    if (setup) begin
      rdata_nxt = apb_i.pwrite ? `EPC_ZERO32 : rd_val;
      err_nxt = !hit;
    end
  end
  // register writes at the access edge
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    mode4_nxt = mode4_r;
    pthr_nxt = pthr_r;
    cthr_nxt = cthr_r;
    imask_nxt = imask_r;
    ist_nxt = ist_r;
    if (wr_acc) begin
      case (idx)
        `EPC_IDX_CTRL1: ctrl1_nxt = epc_ctrl1_t'(apb_i.pwdata[$bits(epc_ctrl1_t)-1:0]);
        `EPC_IDX_CTRL2: mode4_nxt = epc_in_mode_t'(apb_i.pwdata[`EPC_MODE4_LSB +: `EPC_MODE4_W]);
        `EPC_IDX_PTHR: pthr_nxt = apb_i.pwdata[ACC_W-1:0];
        `EPC_IDX_CTHR: cthr_nxt = apb_i.pwdata[ACC_W-1:0];
        `EPC_IDX_IMASK: imask_nxt = apb_i.pwdata[`EPC_EV_W-1:0];
        `EPC_IDX_ISTAT: ist_nxt = ist_r & ~apb_i.pwdata[`EPC_EV_W-1:0];
        default: ist_nxt = ist_r;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    ist_nxt = ist_nxt | ev;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_r <= '0;
      mode4_r <= EPC_IN_POWER;
      pthr_r <= '0;
      cthr_r <= '0;
      imask_r <= '0;
      ist_r <= '0;
      rdata_r <= `EPC_ZERO32;
      err_r <= 1'b0;
    end else if (ce_i) begin
      ctrl1_r <= ctrl1_nxt;
      mode4_r <= mode4_nxt;
      pthr_r <= pthr_nxt;
      cthr_r <= cthr_nxt;
      imask_r <= imask_nxt;
      ist_r <= ist_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end
  // answer: zero wait states while ce is high
  always_comb begin
    apb_o.prdata = rdata_r;
    apb_o.pready = ce_i;
    apb_o.pslverr = apb_i.psel && apb_i.penable && err_r;
  end
  assign irq_o = |(ist_r & imask_r);
  //////////////////////////////////////////////////////////////////
  // accumulation tick divider
  always_comb begin
    tick = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick ? '0 : TICK_W'(tick_cnt_r + 1'b1);
  end
  assign width = WID_W'(PULSE_CYC >> ctrl1_r.energy_pulse_width_select);
  // accumulator one gated by its enable; creep also clears it
  assign en1 = ctrl1_r.accumulator_one_enable && !creep_r;
  // accumulator two gated by its enable; creep also clears it
  assign en2 = ctrl1_r.accumulator_two_enable && !creep_r;
  epc_pulse_gen #(.ACC_W(ACC_W), .WID_W(WID_W)) u_pg1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(en1),
    .tick_i(tick),
    .power_i(power1_i),
    .thresh_i(pthr_r),
    .speed_i(ctrl1_r.energy_pulse_speedup),
    .width_i(width),
    .acc_o(acc1),
    .pulse_o(p1),
    .fire_o(f1)
  );
  epc_pulse_gen #(.ACC_W(ACC_W), .WID_W(WID_W)) u_pg2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(en2),
    .tick_i(tick),
    .power_i(power2_i),
    .thresh_i(pthr_r),
    .speed_i(ctrl1_r.energy_pulse_speedup),
    .width_i(width),
    .acc_o(acc2),
    .pulse_o(p2),
    .fire_o(f2)
  );
  //////////////////////////////////////////////////////////////////
  // processing next state
  always_comb begin
    fast_nxt = fast_r;
    crun_nxt = crun_r;
    creep_nxt = creep_r;
    acc4_nxt = acc4_r;
    src_pulse = ctrl1_r.pulse_one_source_select ? p2 : p1;
    // disabled output rests at its inactive level
    out_nxt = ctrl1_r.pulse_one_polarity_invert;
    if (ctrl1_r.pulse_one_out_enable) begin
      out_nxt = src_pulse ^ ctrl1_r.pulse_one_polarity_invert;
    end
    // fast accumulator adds every clock, wraps
    if (ctrl1_r.fast_accumulator_enable) begin
      fast_nxt = ACC_W'(fast_r + power1_i);
    end
    // detection off clears run and status
    if (!ctrl1_r.creep_detect_enable) begin
      crun_nxt = '0;
      creep_nxt = 1'b0;
    end else if (avg_valid_i) begin
      // three below-threshold averages in a row
      if (avg_power_i < cthr_r) begin
        crun_nxt = (crun_r == `EPC_CREEP_RUN) ? crun_r : 2'(crun_r + 1'b1);
        creep_nxt = (crun_nxt == `EPC_CREEP_RUN);
      end else begin
        crun_nxt = '0;
        creep_nxt = 1'b0;
      end
    end
    case (mode4_r)
      EPC_IN_POWER: acc4_nxt = power1_i;
      EPC_IN_IRMS: acc4_nxt = irms_i;
      EPC_IN_CONST: acc4_nxt = CONST_VAL;
      EPC_IN_FUND: acc4_nxt = fund_i;
      default: acc4_nxt = power1_i;
    endcase
  end
  // events: crossings of both counters and creep entry
  always_comb begin
    ev = '0;
    ev[`EPC_EV_P1] = f1;
    ev[`EPC_EV_P2] = f2;
    ev[`EPC_EV_CRP] = creep_nxt && !creep_r;
  end
  // processing registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      fast_r <= '0;
      crun_r <= '0;
      creep_r <= 1'b0;
      acc4_r <= '0;
      out_r <= 1'b0;
    end else if (ce_i) begin
      tick_cnt_r <= tick_cnt_nxt;
      fast_r <= fast_nxt;
      crun_r <= crun_nxt;
      creep_r <= creep_nxt;
      acc4_r <= acc4_nxt;
      out_r <= out_nxt;
    end
  end
  assign energy_pulse_out_one_o = out_r;
  assign acc4_in_o = acc4_r;
  assign creep_o = creep_r;
  //////////////////////////////////////////////////////////////////
  // checks
  sequence s_below;
    ctrl1_r.creep_detect_enable && avg_valid_i && avg_power_i < cthr_r;
  endsequence
  property p_out_gate;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !ctrl1_r.pulse_one_out_enable)
        |=> (energy_pulse_out_one_o == $past(ctrl1_r.pulse_one_polarity_invert));
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("disabled output moved");
  property p_src_sel;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ctrl1_r.pulse_one_out_enable && !ctrl1_r.pulse_one_polarity_invert)
        |=> (energy_pulse_out_one_o == $past(ctrl1_r.pulse_one_source_select ? p2 : p1));
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("wrong pulse source");
  property p_inv;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ctrl1_r.pulse_one_out_enable && ctrl1_r.pulse_one_polarity_invert)
        |=> (energy_pulse_out_one_o == !$past(src_pulse));
  endproperty
  a_inv: assert property (p_inv) else $error("polarity not inverted");
  property p_acc2_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !ctrl1_r.accumulator_two_enable) |=> (acc2 == '0);
  endproperty
  a_acc2_off: assert property (p_acc2_off) else $error("accumulator two ran disabled");
  property p_acc1_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !ctrl1_r.accumulator_one_enable) |=> (acc1 == '0 && !f1);
  endproperty
  a_acc1_off: assert property (p_acc1_off) else $error("accumulator one ran disabled");
  property p_tick_period;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && tick) |=> (!tick && tick_cnt_r == '0);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period broken");
  property p_creep_set;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (s_below and (ce_i && crun_r == 2'h2)) |=> creep_o;
  endproperty
  a_creep_set: assert property (p_creep_set) else $error("creep not raised");
  property p_creep_irq;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ev[`EPC_EV_CRP] && imask_r[`EPC_EV_CRP]) |=> irq_o;
  endproperty
  a_creep_irq: assert property (p_creep_irq) else $error("creep gave no interrupt");
  property p_creep_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !ctrl1_r.creep_detect_enable) |=> !creep_o;
  endproperty
  a_creep_off: assert property (p_creep_off) else $error("creep while disabled");
  property p_fast_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !ctrl1_r.fast_accumulator_enable) |=> $stable(fast_r);
  endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast accumulator moved");
  property p_mode4;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode4_r == EPC_IN_IRMS) |=> (acc4_in_o == $past(irms_i));
  endproperty
  a_mode4: assert property (p_mode4) else $error("accumulator four input wrong");
  property p_mode4_fund;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && mode4_r == EPC_IN_FUND) |=> (acc4_in_o == $past(fund_i));
  endproperty
  a_mode4_fund: assert property (p_mode4_fund) else $error("fundamental not selected");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && f1 && imask_r[`EPC_EV_P1]) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("crossing gave no interrupt");
endmodule // epc_top

// [shared/epc_defs.svh]
// constants for the energy pulse output control block
// assumes: 100 MHz core clock, registers on a 32-bit APB
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
// clock and accumulation rate (204.8 KHz)
`define EPC_CLK_HZ 100000000
`define EPC_ACC_RATE_HZ 204800
`define EPC_TICK_DIV (`EPC_CLK_HZ / `EPC_ACC_RATE_HZ)
// widest pulse width, in ms, and its cycle count
`define EPC_PULSE_BASE_MS 80
`define EPC_PULSE_CYC_BASE (`EPC_CLK_HZ / 1000 * `EPC_PULSE_BASE_MS)
// register indices; byte address is four times the index
`define EPC_IDX_CTRL1 6'h03
`define EPC_IDX_CTRL2 6'h04
`define EPC_IDX_PTHR 6'h05
`define EPC_IDX_CTHR 6'h06
`define EPC_IDX_ISTAT 6'h07
`define EPC_IDX_IMASK 6'h08
`define EPC_IDX_FAST 6'h09
`define EPC_IDX_ACC1 6'h0A
`define EPC_IDX_ACC2 6'h0B
// writable bits of the control registers
`define EPC_CTRL1_WMASK 32'h000007FF
`define EPC_CTRL2_WMASK 32'hC0000000
// accumulator-four mode field of the second control register
`define EPC_MODE4_LSB 30
`define EPC_MODE4_W 2
`define EPC_ZERO32 32'h00000000
// interrupt status layout
`define EPC_EV_W 3
`define EPC_EV_P1 0
`define EPC_EV_P2 1
`define EPC_EV_CRP 2
`define EPC_ST_LIVE 8
// creep run length and speed-up shifts
`define EPC_CREEP_RUN 2'h3
`define EPC_SH_X4 3'h2
`define EPC_SH_X8 3'h3
`define EPC_SH_X16 3'h4
`endif

// [shared/epc_pkg.sv]
// types for the energy pulse output control block
// assumes: constants come from epc_defs.svh
package epc_pkg;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } epc_apb_req_t;
  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } epc_apb_rsp_t;
  // low field block of the first metering control register
  typedef struct packed {
    logic pulse_one_polarity_invert;
    logic pulse_one_out_enable;
    logic pulse_one_source_select;
    logic accumulator_two_enable;
    logic accumulator_one_enable;
    logic [1:0] energy_pulse_width_select;
    logic [1:0] energy_pulse_speedup;
    logic creep_detect_enable;
    logic fast_accumulator_enable;
  } epc_ctrl1_t;
  // input choice of the fourth accumulator
  typedef enum logic [1:0] {EPC_IN_POWER, EPC_IN_IRMS, EPC_IN_CONST, EPC_IN_FUND} epc_in_mode_t;
  // pulse generator states
  typedef enum logic {EPC_PG_IDLE, EPC_PG_HIGH} epc_pg_state_t;
endpackage

// [testbench/energy_pulse_output_control_tb_top.sv]
// self-checking bench for epc_top with a far-side pulse counter
// assumes: ce_i high outside one freeze test, so apb accesses end in one cycle
`timescale 1ns/100ps
`include "epc_defs.svh"
module energy_pulse_output_control_tb_top;
  import epc_pkg::*;
  localparam int PC = 64;
  localparam int TK = 488;
  logic clk_i, rst_i, avg_v, low, pin, creep, irq, e, ce;
  epc_apb_req_t req;
  epc_apb_rsp_t rsp;
  logic [31:0] p1, p2, irms, fund, avg, acc4, q, wid, hold;
  logic [31:0] cfg [5] = '{32'h240, 32'h040, 32'h340, 32'h380, 32'h280};
  logic [15:0] cnt, c0;
  int n_mismatch, checked;
  epc_top #(.ACC_W(32), .PULSE_CYC(PC), .CONST_VAL(32'h1)) epc_top_i (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce), .apb_i(req), .apb_o(rsp), .power1_i(p1), .power2_i(p2),
    .irms_i(irms), .fund_i(fund), .avg_power_i(avg), .avg_valid_i(avg_v),
    .energy_pulse_out_one_o(pin), .acc4_in_o(acc4), .creep_o(creep), .irq_o(irq));
  epc_pulse_counter epc_pulse_counter_i (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin),
    .low_i(low), .count_o(cnt), .width_o(wid));
  ////////////////////////////////////////////////////////////////////////
  // verdict and shared helpers
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, s);
      n_mismatch++;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one apb transfer; read data taken at the edge that sees pready
  task apb(input logic w, input logic [5:0] ix, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:{ix, 2'b00}, pwdata:d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    #1;
  endtask
  task wr(input logic [5:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
  endtask
  task rd(input string nm, input logic [5:0] ix, input logic [31:0] x);
    apb(1'b0, ix, 32'h0);
    chk(nm, q, x);
  endtask
  // one averaged-power strobe, then room for the status to settle
  task strb(input logic [31:0] v);
    @(posedge clk_i);
    avg <= v;
    avg_v <= 1'b1;
    @(posedge clk_i);
    avg_v <= 1'b0;
    cyc(2);
  endtask
  // bounded wait for the next pulse at the far side
  task wpulse;
    int n;
    c0 = cnt;
    for (n = 0; n < 1200 && cnt == c0; n++) @(posedge clk_i);
    if (cnt == c0) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task tdone(input string nm);
    $display("test %s done", nm);
  endtask
  // pulses in 20 or 21 ticks: 90 per tick, 1600 per pulse, shifted
  function automatic logic [31:0] exp_cnt(input int s);
    int sh;
    sh = (s == 0) ? 0 : s + 1;
    return 32'(20 * 90 / (1600 >> sh));
  endfunction
  function automatic logic [31:0] exp_a4(input int m);
    case (m)
      0: return p1;
      1: return irms;
      2: return 32'h1;
      default: return fund;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    req = '0;
    {p1, p2, irms, fund, avg, avg_v, low, n_mismatch, checked} = '0;
    void'($urandom(74704));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl1", `EPC_IDX_CTRL1, 32'h0);
    rd("ctrl2", `EPC_IDX_CTRL2, 32'h0);
    chk("irq", {pin, creep, irq}, 32'h0);
    apb(1'b0, 6'h3F, 32'h0);
    chk("slverr", e, 32'h1);
    wr(`EPC_IDX_CTRL1, 32'hFFFFFFFF);
    rd("ctrl1 rw", `EPC_IDX_CTRL1, `EPC_CTRL1_WMASK);
    wr(`EPC_IDX_CTRL1, 32'h0);
    tdone("reset");
    @(posedge clk_i);
    p1 <= 1000;
    p2 <= 1000;
    wr(`EPC_IDX_PTHR, 32'h10);
    wr(`EPC_IDX_IMASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(`EPC_IDX_CTRL1, cfg[i]);
      c0 = cnt;
      cyc(1100);
      chk("pulses", 32'(cnt != c0), 32'(i % 3 == 0));
      wr(`EPC_IDX_CTRL1, 32'h0);
    end
    chk("irq p1", irq, 32'h1);
    wr(`EPC_IDX_IMASK, 32'h0);
    tdone("source");
    for (int w = 0; w < 4; w++) begin
      wr(`EPC_IDX_CTRL1, 32'(w % 2) << 10);
      cyc(3);
      chk("idle", pin, 32'(w % 2));
      @(posedge clk_i);
      low <= w[0];
      wr(`EPC_IDX_CTRL1, (32'(w % 2) << 10) | 32'h240 | (32'(w) << 4));
      wpulse();
      cyc(PC + 8);
      chk("width", wid, 32'(PC >> w));
      wr(`EPC_IDX_CTRL1, 32'h0);
    end
    @(posedge clk_i);
    low <= 1'b0;
    tdone("width");
    @(posedge clk_i);
    p1 <= 90;
    wr(`EPC_IDX_PTHR, 32'd1600);
    for (int s = 0; s < 4; s++) begin
      wr(`EPC_IDX_CTRL1, 32'h270 | (32'(s) << 2));
      c0 = cnt;
      cyc(TK * 20 + TK / 2);
      chk("rate", 32'(cnt - c0), exp_cnt(s));
      wr(`EPC_IDX_CTRL1, 32'h0);
    end
    tdone("rate");
    @(posedge clk_i);
    p1 <= $urandom_range(1, 4095);
    p2 <= $urandom_range(1, 4095);
    wr(`EPC_IDX_PTHR, 32'hFFFFFFFF);
    wr(`EPC_IDX_CTRL1, 32'h0C1);
    cyc(TK * 3);
    apb(1'b0, `EPC_IDX_ACC1, 32'h0);
    chk("acc1", 32'(q != 0 && q % p1 == 0), 32'h1);
    apb(1'b0, `EPC_IDX_ACC2, 32'h0);
    chk("acc2", 32'(q != 0 && q % p2 == 0), 32'h1);
    apb(1'b0, `EPC_IDX_FAST, 32'h0);
    chk("fast", 32'(q != 0 && q % p1 == 0), 32'h1);
    wr(`EPC_IDX_CTRL1, 32'h0);
    rd("acc1 off", `EPC_IDX_ACC1, 32'h0);
    rd("acc2 off", `EPC_IDX_ACC2, 32'h0);
    // disabled fast accumulator holds its sum
    apb(1'b0, `EPC_IDX_FAST, 32'h0);
    hold = q;
    cyc(5);
    rd("fast held", `EPC_IDX_FAST, hold);
    tdone("accum");
    @(posedge clk_i);
    irms <= $urandom;
    fund <= $urandom;
    for (int m = 0; m < 4; m++) begin
      wr(`EPC_IDX_CTRL2, 32'(m) << 30);
      cyc(2);
      chk("acc4", acc4, exp_a4(m));
    end
    // clock enable low freezes the registered mux
    hold = fund;
    @(posedge clk_i);
    ce <= 1'b0;
    fund <= ~fund;
    cyc(3);
    chk("ce freeze", acc4, hold);
    @(posedge clk_i);
    ce <= 1'b1;
    cyc(2);
    chk("ce run", acc4, fund);
    tdone("mode");
    rd("istat", `EPC_IDX_ISTAT, 32'h3);
    chk("irq masked", irq, 32'h0);
    wr(`EPC_IDX_ISTAT, 32'h7);
    wr(`EPC_IDX_CTHR, 32'd1000);
    wr(`EPC_IDX_IMASK, 32'h4);
    wr(`EPC_IDX_CTRL1, 32'h2);
    strb(500);
    strb(500);
    chk("creep 2", creep, 32'h0);
    strb(500);
    chk("creep 3", creep, 32'h1);
    chk("irq", irq, 32'h1);
    rd("istat", `EPC_IDX_ISTAT, 32'h104);
    wr(`EPC_IDX_ISTAT, 32'h4);
    chk("irq clr", irq, 32'h0);
    strb(2000);
    chk("creep out", creep, 32'h0);
    wr(`EPC_IDX_CTRL1, 32'h0);
    repeat (3) strb(500);
    chk("creep off", creep, 32'h0);
    tdone("creep");
    // reset again in mid-run, after a full configuration
    wr(`EPC_IDX_CTRL1, 32'hFFFFFFFF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl1 rst", `EPC_IDX_CTRL1, 32'h0);
    rd("ctrl2 rst", `EPC_IDX_CTRL2, 32'h0);
    rd("fast rst", `EPC_IDX_FAST, 32'h0);
    tdone("reset again");
    report_and_stop();
  end
endmodule // energy_pulse_output_control_tb_top

// [testbench/epc_pulse_counter.sv]
// far-side pulse counter watching pulse output one
// assumes: pulse pin is registered on clk_i
`timescale 1ns/100ps
module epc_pulse_counter (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic pin_i, // pulse pin
  input wire logic low_i, // pin is active low
  output logic [15:0] count_o, // pulses seen
  output logic [31:0] width_o // last pulse width, cycles
);
  logic act_r;
  logic [31:0] run_r;
  // count leading edges and time each active phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_r <= 1'b0;
      run_r <= 32'h0;
      count_o <= 16'h0;
      width_o <= 32'h0;
    end else begin
      act_r <= pin_i ^ low_i;
      run_r <= (pin_i ^ low_i) ? run_r + 32'h1 : 32'h0;
      if ((pin_i ^ low_i) && !act_r) count_o <= count_o + 16'h1;
      if (!(pin_i ^ low_i) && act_r) width_o <= run_r;
    end
  end
endmodule // epc_pulse_counter
